// [io_term_consts.svh]
// constants for the stepper drive terminal logic
`ifndef IO_TERM_CONSTS_SVH
`define IO_TERM_CONSTS_SVH
`define DATA_W 16
`define ADDR_W 8
`define CLK_MHZ 10
`define FILTER_US 100
`define REG_ERR_CODE 8'h06
`define REG_MOTION 8'h07
`define REG_IN_STAT 8'h08
`define REG_OUT_STAT 8'h09
`define REG_CTRL_MODE 8'h10
`define REG_IN_FN0 8'h11
`define REG_OUT_FN0 8'h16
`define NUM_IN 5
`define NUM_OUT 3
`define CTRL_MODE_RST 2'h0
`define IN_FN_RST {4'h6, 4'h8, 4'h6, 4'h5, 4'h4}
`define OUT_FN_RST {3'h4, 3'h2, 3'h1}
`define ERR_NONE 3'h0
`define ERR_OVER_CUR 3'h1
`define ERR_OVER_VOLT 3'h2
`define ERR_UNDER_VOLT 3'h3
`define ERR_MEMORY 3'h4
`define ERR_TRACKING 3'h5
`define MS_POS_OK 0
`define MS_HOME_DONE 1
`define MS_RUNNING 2
`define MS_ALARM 3
`define MS_RELEASED 4
`define IS_PULSE 0
`define IS_DIR 1
`define IS_GEN0 2
`endif

// [io_term_pkg.sv]
// types for the stepper drive terminal logic
package io_term_pkg;
  typedef enum logic [1:0] {
    MODE_BUS = 2'h0,
    MODE_PULSE_DIR = 2'h1,
    MODE_DOUBLE_PULSE = 2'h2
  } ctrl_mode_t;
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_ORIGIN = 4'h1, FN_FWD_LIMIT = 4'h2,
    FN_BWD_LIMIT = 4'h3, FN_ENABLE = 4'h4, FN_RELEASE = 4'h5,
    FN_ALM_CLEAR = 4'h6, FN_RESTORE = 4'h7, FN_STOP = 4'h8,
    FN_ESTOP = 4'h9, FN_POS_MOVE = 4'ha, FN_SPEED_MOVE = 4'hb,
    FN_JOG_FWD = 4'hc, FN_JOG_BACK = 4'hd, FN_HOME_EN = 4'he,
    FN_MULTI_EN = 4'hf
  } in_fn_t;
  typedef enum logic [2:0] {
    OF_NONE = 3'h0, OF_ALARM = 3'h1, OF_RUNNING = 3'h2,
    OF_HOME_DONE = 3'h3, OF_POS_OK = 3'h4, OF_MULTI_MODE = 3'h5,
    OF_SEG_STATUS = 3'h6
  } out_fn_t;
endpackage : io_term_pkg

// [filt_if.sv]
// raw and filtered general input levels
`timescale 1ns/1ps
`default_nettype none
interface filt_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  modport src (output raw, input level, input rise);
  modport flt (input raw, output level, output rise);
endinterface : filt_if
`default_nettype wire

// [input_filter.sv]
// synchroniser and debounce filter for general inputs
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
  parameter int W = 5,
  parameter int CYCLES = 1000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  filt_if.flt port
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] rise_q;
  logic [W-1:0][CW-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= port.raw;
      s2_q <= s1_q;
    end
  end

  // level follows only after CYCLES stable samples [R26]
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lvl_q <= '0;
      rise_q <= '0;
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        rise_q[i] <= 1'b0;
        if (s2_q[i] == lvl_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == CW'(CYCLES - 1)) begin
          cnt_q[i] <= '0;
          lvl_q[i] <= s2_q[i];
          rise_q[i] <= s2_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign port.level = lvl_q;
  assign port.rise = rise_q;
endmodule : input_filter
`default_nettype wire

// [stepper_io_terminals.sv]
// terminal function logic of the stepper drive
//
// Operation
// R1: step pulses accepted only in external modes
// R2: direction honoured only in external modes
// R3: external mode honours enable, release, clear, restore
// R4: external mode drives alarm, running, position only
// R5: enable input locks and holds motor
// R6: release input de-energises the motor
// R7: alarm clear clears memory and comm errors
// R8: voltage alarms clear themselves when condition ends
// R9: restore input returns parameters to defaults
// R10: stop input decelerates motor to standstill
// R11: emergency stop halts without ramp
// R12: position trigger starts position-mode move
// R13: speed trigger starts speed-mode move
// R14: forward jog moves motor forward
// R15: backward jog moves motor in reverse
// R16: homing input starts return-to-origin with sensors
// R17: multi-position trigger starts segment move
// R18: alarm output active while any alarm present
// R19: homing-done output after origin return completes
// R20: running output follows motor rotation
// R21: position-reached output in position mode
// R22: multi-position mode and status outputs
// R23: input status word, bits 7-15 zero
// R24: output status word in bits 0-2
// R25: error code zero or one to five
// R26: inputs synchronised, debounced, triggers on edges
// R27: estop beats stop beats motion triggers
//
// Added by the designer: the address-and-strobe port and the register addresses.
`include "io_term_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module stepper_io_terminals import io_term_pkg::*; #(
  parameter int FILTER_CYCLES = `FILTER_US * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DATA_W-1:0] rdata_o,
  input wire logic step_pulse_in_i,
  input wire logic step_direction_in_i,
  input wire logic [`NUM_IN-1:0] general_input_i,
  input wire logic over_current_i,
  input wire logic over_voltage_i,
  input wire logic under_voltage_i,
  input wire logic mem_error_i,
  input wire logic comm_error_i,
  input wire logic track_error_i,
  input wire logic running_i,
  input wire logic home_done_i,
  input wire logic pos_reached_i,
  input wire logic multi_mode_i,
  input wire logic [`NUM_OUT-1:0] segment_status_i,
  output logic [`NUM_OUT-1:0] general_output_o,
  output logic step_pulse_o,
  output logic step_dir_o,
  output logic motor_lock_o,
  output logic motor_release_o,
  output logic params_restore_o,
  output logic stop_o,
  output logic estop_o,
  output logic pos_move_o,
  output logic speed_move_o,
  output logic jog_fwd_o,
  output logic jog_back_o,
  output logic home_start_o,
  output logic multi_start_o,
  output logic [`NUM_IN-1:0] segment_select_o,
  output logic origin_o,
  output logic fwd_limit_o,
  output logic bwd_limit_o
);
  localparam int NI = `NUM_IN;
  localparam int NO = `NUM_OUT;

  // inputs whose function is code
  function automatic logic [NI-1:0] fn_hit(
    input logic [NI-1:0][3:0] fns,
    input logic [NI-1:0] v,
    input in_fn_t code
  );
    logic [NI-1:0] m;
    m = '0;
    for (int k = 0; k < NI; k++) begin
      m[k] = v[k] && (fns[k] == code);
    end
    return m;
  endfunction : fn_hit

  ctrl_mode_t mode_q;
  logic [NI-1:0][3:0] in_fn_q;
  logic [NO-1:0][2:0] out_fn_q;
  logic [1:0] pu_s_q;
  logic [1:0] dr_s_q;
  logic pu_prev_q;
  logic oc_q;
  logic mem_q;
  logic comm_q;
  logic trk_q;
  logic [2:0] err_q;
  logic alarm_q;
  logic [`DATA_W-1:0] rdata_q;
  logic [NO-1:0] out_d;
  logic [2:0] err_d;
  logic [`DATA_W-1:0] rd_mux;
  logic ext;
  logic cmd_ok;
  logic clr_r;
  logic restore_r;
  logic estop_r;
  logic stop_r;
  logic mv_ok;
  logic [NI-1:0] lvl;
  logic [NI-1:0] rise;

  filt_if #(.W(NI)) gin ();
  assign gin.raw = general_input_i;

  input_filter #(.W(NI), .CYCLES(FILTER_CYCLES)) u_filt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .port(gin.flt)
  );

  assign lvl = gin.level;
  assign rise = gin.rise;
  assign ext = (mode_q == MODE_PULSE_DIR) || (mode_q == MODE_DOUBLE_PULSE);
  assign cmd_ok = !ext; // [R3]
  assign clr_r = |fn_hit(in_fn_q, rise, FN_ALM_CLEAR);
  assign restore_r = |fn_hit(in_fn_q, rise, FN_RESTORE);
  assign estop_r = cmd_ok && |fn_hit(in_fn_q, rise, FN_ESTOP);
  assign stop_r = cmd_ok && !estop_r && |fn_hit(in_fn_q, rise, FN_STOP); // [R27]
  assign mv_ok = cmd_ok && !estop_r && !stop_r; // [R27]

  // high-speed differential pins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pu_s_q <= '0;
      dr_s_q <= '0;
      pu_prev_q <= 1'b0;
    end else begin
      pu_s_q <= {pu_s_q[0], step_pulse_in_i};
      dr_s_q <= {dr_s_q[0], step_direction_in_i};
      pu_prev_q <= pu_s_q[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      step_pulse_o <= 1'b0;
      step_dir_o <= 1'b0;
    end else begin
      step_pulse_o <= ext && pu_s_q[1] && !pu_prev_q; // [R1]
      step_dir_o <= ext && dr_s_q[1]; // [R2]
    end
  end

  // software registers, restored by the restore input
  always_ff @(posedge clk_i) begin
    if (srst_i || restore_r) begin // [R9]
      mode_q <= ctrl_mode_t'(`CTRL_MODE_RST);
      in_fn_q <= `IN_FN_RST;
      out_fn_q <= `OUT_FN_RST;
    end else if (wr_i) begin
      if (addr_i == `REG_CTRL_MODE) begin
        mode_q <= ctrl_mode_t'(wdata_i[1:0]);
      end
      for (int k = 0; k < NI; k++) begin
        if (addr_i == `REG_IN_FN0 + `ADDR_W'(k)) begin
          in_fn_q[k] <= wdata_i[3:0];
        end
      end
      for (int k = 0; k < NO; k++) begin
        if (addr_i == `REG_OUT_FN0 + `ADDR_W'(k)) begin
          out_fn_q[k] <= wdata_i[2:0];
        end
      end
    end
  end

  // holding and release levels
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      motor_lock_o <= 1'b0;
      motor_release_o <= 1'b0;
      params_restore_o <= 1'b0;
    end else begin
      motor_release_o <= |fn_hit(in_fn_q, lvl, FN_RELEASE); // [R6]
      motor_lock_o <= |fn_hit(in_fn_q, lvl, FN_ENABLE) &&
        !(|fn_hit(in_fn_q, lvl, FN_RELEASE)); // [R5]
      params_restore_o <= restore_r; // [R9]
    end
  end

  // motion commands, one-cycle pulses
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      estop_o <= 1'b0;
      stop_o <= 1'b0;
      pos_move_o <= 1'b0;
      speed_move_o <= 1'b0;
      jog_fwd_o <= 1'b0;
      jog_back_o <= 1'b0;
      home_start_o <= 1'b0;
      multi_start_o <= 1'b0;
    end else begin
      estop_o <= estop_r; // [R11]
      stop_o <= stop_r; // [R10]
      pos_move_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_POS_MOVE); // [R12]
      speed_move_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_SPEED_MOVE); // [R13]
      jog_fwd_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_JOG_FWD); // [R14]
      jog_back_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_JOG_BACK); // [R15]
      home_start_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_HOME_EN); // [R16]
      multi_start_o <= mv_ok && |fn_hit(in_fn_q, rise, FN_MULTI_EN); // [R17]
    end
  end

  // sensor levels for homing and segment select
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      origin_o <= 1'b0;
      fwd_limit_o <= 1'b0;
      bwd_limit_o <= 1'b0;
      segment_select_o <= '0;
    end else begin
      origin_o <= cmd_ok && |fn_hit(in_fn_q, lvl, FN_ORIGIN); // [R16]
      fwd_limit_o <= cmd_ok && |fn_hit(in_fn_q, lvl, FN_FWD_LIMIT); // [R16]
      bwd_limit_o <= cmd_ok && |fn_hit(in_fn_q, lvl, FN_BWD_LIMIT); // [R16]
      segment_select_o <= cmd_ok ? lvl : '0; // [R17]
    end
  end

  // latched alarms; a new event wins over clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      oc_q <= 1'b0;
      mem_q <= 1'b0;
      comm_q <= 1'b0;
      trk_q <= 1'b0;
    end else begin
      oc_q <= over_current_i || (oc_q && !clr_r);
      mem_q <= mem_error_i || (mem_q && !clr_r); // [R7]
      comm_q <= comm_error_i || (comm_q && !clr_r); // [R7]
      trk_q <= track_error_i || (trk_q && !clr_r);
    end
  end

  // voltage alarms read live, so they clear themselves [R8]
  always_comb begin
    if (oc_q) err_d = `ERR_OVER_CUR; // [R25]
    else if (over_voltage_i) err_d = `ERR_OVER_VOLT;
    else if (under_voltage_i) err_d = `ERR_UNDER_VOLT;
    else if (mem_q) err_d = `ERR_MEMORY;
    else if (trk_q) err_d = `ERR_TRACKING;
    else err_d = `ERR_NONE;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_q <= `ERR_NONE;
      alarm_q <= 1'b0;
    end else begin
      err_q <= err_d;
      alarm_q <= (err_d != `ERR_NONE) || comm_q; // [R18]
    end
  end

  // output terminal functions
  always_comb begin
    for (int k = 0; k < NO; k++) begin
      case (out_fn_t'(out_fn_q[k]))
        OF_ALARM: out_d[k] = alarm_q; // [R18]
        OF_RUNNING: out_d[k] = running_i; // [R20]
        OF_POS_OK: out_d[k] = pos_reached_i; // [R21]
        OF_HOME_DONE: out_d[k] = cmd_ok && home_done_i; // [R19] [R4]
        OF_MULTI_MODE: out_d[k] = cmd_ok && multi_mode_i; // [R22] [R4]
        OF_SEG_STATUS: out_d[k] = cmd_ok && segment_status_i[k]; // [R22]
        default: out_d[k] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      general_output_o <= '0;
    end else begin
      general_output_o <= out_d;
    end
  end

  // register read mux
  always_comb begin
    rd_mux = '0;
    case (addr_i)
      `REG_ERR_CODE: rd_mux[2:0] = err_q; // [R25]
      `REG_MOTION: begin
        rd_mux[`MS_POS_OK] = pos_reached_i;
        rd_mux[`MS_HOME_DONE] = home_done_i;
        rd_mux[`MS_RUNNING] = running_i;
        rd_mux[`MS_ALARM] = alarm_q;
        rd_mux[`MS_RELEASED] = motor_release_o;
      end
      `REG_IN_STAT: begin
        rd_mux[`IS_PULSE] = pu_s_q[1]; // [R23]
        rd_mux[`IS_DIR] = dr_s_q[1]; // [R23]
        rd_mux[`IS_GEN0 +: NI] = lvl; // [R23]
      end
      `REG_OUT_STAT: rd_mux[NO-1:0] = general_output_o; // [R24]
      `REG_CTRL_MODE: rd_mux[1:0] = mode_q;
      default: begin
        for (int k = 0; k < NI; k++) begin
          if (addr_i == `REG_IN_FN0 + `ADDR_W'(k)) rd_mux[3:0] = in_fn_q[k];
        end
        for (int k = 0; k < NO; k++) begin
          if (addr_i == `REG_OUT_FN0 + `ADDR_W'(k)) rd_mux[2:0] = out_fn_q[k];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rd_mux : '0;
    end
  end
  assign rdata_o = rdata_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  pulse_gate_a: assert property ( // [R1]
    step_pulse_o |-> $past(ext)
  ) else $error("step pulse passed outside external mode");

  dir_gate_a: assert property ( // [R2]
    !ext && $past(!ext) |-> !step_dir_o
  ) else $error("direction passed outside external mode");

  ext_inputs_a: assert property ( // [R3]
    $past(ext) |-> !(stop_o || estop_o || pos_move_o || jog_fwd_o
      || multi_start_o || origin_o)
  ) else $error("input function acted in external mode");

  estop_prio_a: assert property ( // [R27]
    estop_o |-> !stop_o && !pos_move_o && !speed_move_o && !home_start_o
  ) else $error("estop did not win");

  lock_release_a: assert property ( // [R5]
    motor_lock_o |-> !motor_release_o
  ) else $error("lock while released");

  mem_clear_a: assert property ( // [R7]
    clr_r && !mem_error_i |=> !mem_q
  ) else $error("memory error not cleared");

  volt_self_a: assert property ( // [R8]
    !oc_q && !over_voltage_i && !under_voltage_i && !mem_q && !trk_q
      && !comm_q |=> !alarm_q
  ) else $error("voltage alarm did not self clear");

  alarm_out_a: assert property ( // [R18]
    err_q != `ERR_NONE |-> alarm_q
  ) else $error("alarm flag missing");

  err_range_a: assert property ( // [R25]
    err_q <= `ERR_TRACKING
  ) else $error("error code out of range");

  instat_pad_a: assert property ( // [R23]
    rd_i && addr_i == `REG_IN_STAT |=> rdata_o[`DATA_W-1:7] == '0
  ) else $error("input status upper bits not zero");

  restore_a: assert property ( // [R9]
    restore_r |=> mode_q == ctrl_mode_t'(`CTRL_MODE_RST) && params_restore_o
  ) else $error("restore did not reset parameters");

  estop_c: cover property (estop_o);
  jog_c: cover property (jog_fwd_o ##[1:50] jog_back_o);
  ext_pulse_c: cover property (step_pulse_o && step_dir_o);
  clear_c: cover property (mem_q ##1 !mem_q);
endmodule : stepper_io_terminals
`default_nettype wire

// [motion_ctrl_model.sv]
// far-side model: step controller and terminal sensors
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model (
  input wire logic clk_i,
  output var logic pulse_o,
  output var logic dir_o,
  output var logic [4:0] gen_o
);
  initial begin
    pulse_o = 1'b0;
    dir_o = 1'b0;
    gen_o = 5'h00;
  end
  task automatic set_in(input int k, input logic v);
    @(posedge clk_i);
    gen_o[k] <= v;
  endtask : set_in
  task automatic set_all(input logic [4:0] v);
    @(posedge clk_i);
    gen_o <= v;
  endtask : set_all
  // step train, half sets how slowly it is sent
  task automatic steps(input int n, input logic dv, input int half);
    @(posedge clk_i);
    dir_o <= dv;
    repeat (n) begin
      repeat (half) @(posedge clk_i);
      pulse_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      pulse_o <= 1'b0;
    end
  endtask : steps
endmodule : motion_ctrl_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the stepper drive terminal logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic srst_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rdata_o;
  logic pls, dir;
  logic [4:0] gen;
  logic [5:0] alm;
  logic [6:0] core;
  logic [2:0] gout;
  logic step_p, step_d, lock, rel, rest, orig, fwd, bwd;
  wire [7:0] cmds;
  logic [4:0] sel;
  int num_errors = 0;
  int total_checks = 0;
  int ncmd = 0;
  int npls = 0;
  int nrest = 0;
  logic [7:0] seen = 8'h00;
  always #50 clk_i = ~clk_i;
  motion_ctrl_model u_far (.clk_i(clk_i), .pulse_o(pls), .dir_o(dir),
    .gen_o(gen));
  stepper_io_terminals #(.FILTER_CYCLES(4)) uut (.clk_i(clk_i),
    .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .step_pulse_in_i(pls),
    .step_direction_in_i(dir), .general_input_i(gen),
    .over_current_i(alm[0]), .over_voltage_i(alm[1]),
    .under_voltage_i(alm[2]), .mem_error_i(alm[3]),
    .track_error_i(alm[4]), .comm_error_i(alm[5]), .running_i(core[0]),
    .home_done_i(core[1]), .pos_reached_i(core[2]),
    .multi_mode_i(core[3]), .segment_status_i(core[6:4]),
    .general_output_o(gout), .step_pulse_o(step_p), .step_dir_o(step_d),
    .motor_lock_o(lock), .motor_release_o(rel), .params_restore_o(rest),
    .stop_o(cmds[0]), .estop_o(cmds[1]), .pos_move_o(cmds[2]),
    .speed_move_o(cmds[3]), .jog_fwd_o(cmds[4]), .jog_back_o(cmds[5]),
    .home_start_o(cmds[6]), .multi_start_o(cmds[7]),
    .segment_select_o(sel), .origin_o(orig), .fwd_limit_o(fwd),
    .bwd_limit_o(bwd));
  always @(posedge clk_i) begin
    ncmd <= ncmd + $countones(cmds);
    seen <= seen | cmds;
    npls <= npls + int'(step_p);
    nrest <= nrest + int'(rest);
  end
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({8'h00, got}, {8'h00, exp});
  endtask : chk_pin
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read one word and compare it in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk_reg(rdata_o, exp);
  endtask : rdc
  task automatic settle();
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle
  task automatic clr();
    @(negedge clk_i);
    ncmd = 0;
    npls = 0;
    nrest = 0;
    seen = 8'h00;
  endtask : clr
  task automatic set_alm(input logic [5:0] v);
    @(posedge clk_i);
    alm <= v;
  endtask : set_alm
  task automatic set_core(input logic [6:0] v);
    @(posedge clk_i);
    core <= v;
  endtask : set_core
  task automatic wait_cmd();
    int i;
    for (i = 0; i < 40 && ncmd == 0 && nrest == 0; i++) @(posedge clk_i);
    if (i == 40) begin
      num_errors++;
      wrap_up();
    end
    settle();
  endtask : wait_cmd
  task automatic pulse_clear();
    u_far.set_in(2, 1'b1);
    settle();
    u_far.set_in(2, 1'b0);
    settle();
  endtask : pulse_clear
  task automatic t_reset();
    logic [15:0] dflt [9] = '{0, 4, 5, 6, 8, 6, 1, 2, 4};
    for (int i = 0; i < 9; i++) rdc(8'h10 + 8'(i), dflt[i]);
    wr(8'h06, 16'hffff);
    rdc(8'h06, 16'h0000);
    rdc(8'h30, 16'h0000);
  endtask : t_reset
  task automatic t_cmds();
    for (int c = 8; c < 16; c++) begin
      wr(8'h15, 16'(c));
      clr();
      u_far.set_in(4, 1'b1);
      wait_cmd();
      chk_pin(seen, 8'h01 << (c - 8));
      chk_pin(8'(ncmd), 8'h01);
      if (c == 15) chk_pin({3'h0, sel}, 8'h10);
      u_far.set_in(4, 1'b0);
      settle();
    end
  endtask : t_cmds
  task automatic t_prio();
    wr(8'h11, 16'h0009);
    wr(8'h15, 16'h000a);
    clr();
    u_far.set_all(5'h19);
    wait_cmd();
    chk_pin(seen, 8'h02);
    u_far.set_all(5'h00);
    settle();
    clr();
    u_far.set_all(5'h18);
    wait_cmd();
    chk_pin(seen, 8'h01);
    u_far.set_all(5'h00);
    settle();
    wr(8'h11, 16'h0004);
  endtask : t_prio
  task automatic t_levels();
    u_far.set_in(0, 1'b1);
    settle();
    chk_pin({7'h0, lock}, 8'h01);
    u_far.set_in(1, 1'b1);
    settle();
    chk_pin({7'h0, rel}, 8'h01);
    u_far.set_all(5'h00);
    settle();
    chk_pin({6'h0, lock, rel}, 8'h00);
    for (int k = 1; k < 4; k++) begin
      wr(8'h15, 16'(k));
      u_far.set_in(4, 1'b1);
      settle();
      chk_pin({5'h0, bwd, fwd, orig}, 8'h01 << (k - 1));
      u_far.set_in(4, 1'b0);
      settle();
    end
    wr(8'h15, 16'h0006);
  endtask : t_levels
  task automatic t_alarm();
    for (int i = 0; i < 5; i++) begin
      set_alm(6'h01 << i);
      settle();
      rdc(8'h06, 16'(i + 1));
      chk_pin({7'h0, gout[0]}, 8'h01);
      set_alm(6'h00);
      settle();
      rdc(8'h06, (i == 1 || i == 2) ? 16'h0 : 16'(i + 1));
      pulse_clear();
      rdc(8'h06, 16'h0000);
      chk_pin({7'h0, gout[0]}, 8'h00);
    end
    set_alm(6'h20);
    set_alm(6'h00);
    settle();
    chk_pin({7'h0, gout[0]}, 8'h01);
    pulse_clear();
    chk_pin({7'h0, gout[0]}, 8'h00);
  endtask : t_alarm
  task automatic t_ext();
    for (int m = 0; m < 3; m++) begin
      wr(8'h10, 16'(m));
      clr();
      u_far.steps(3, 1'b1, m + 1);
      settle();
      chk_pin(8'(npls), (m == 0) ? 8'h00 : 8'h03);
      chk_pin({7'h0, step_d}, (m == 0) ? 8'h00 : 8'h01);
      u_far.steps(0, 1'b0, 1);
    end
    clr();
    u_far.set_in(3, 1'b1);
    u_far.set_in(0, 1'b1);
    settle();
    chk_pin(8'(ncmd), 8'h00);
    chk_pin({7'h0, lock}, 8'h01);
    wr(8'h18, 16'h0003);
    set_core(7'h03);
    settle();
    chk_pin({5'h0, gout}, 8'h02);
    rdc(8'h07, 16'h0006);
    wr(8'h10, 16'h0000);
    settle();
    chk_pin({5'h0, gout}, 8'h06);
    u_far.set_all(5'h00);
    set_core(7'h00);
    settle();
    chk_pin({5'h0, gout}, 8'h00);
  endtask : t_ext
  task automatic t_status();
    wr(8'h18, 16'h0004);
    set_core(7'h04);
    settle();
    chk_pin({5'h0, gout}, 8'h04);
    rdc(8'h09, 16'h0004);
    wr(8'h18, 16'h0005);
    set_core(7'h08);
    settle();
    chk_pin({5'h0, gout}, 8'h04);
    wr(8'h16, 16'h0006);
    wr(8'h18, 16'h0006);
    set_core(7'h50);
    settle();
    chk_pin({5'h0, gout}, 8'h05);
    wr(8'h16, 16'h0001);
    wr(8'h18, 16'h0004);
    set_core(7'h00);
    u_far.steps(0, 1'b1, 1);
    u_far.set_all(5'h15);
    settle();
    rdc(8'h08, 16'h0056);
    u_far.set_all(5'h00);
    u_far.steps(0, 1'b0, 1);
    settle();
  endtask : t_status
  task automatic t_restore();
    wr(8'h11, 16'h0009);
    wr(8'h10, 16'h0001);
    wr(8'h15, 16'h0007);
    clr();
    u_far.set_in(4, 1'b1);
    wait_cmd();
    chk_pin(8'(nrest), 8'h01);
    rdc(8'h11, 16'h0004);
    rdc(8'h10, 16'h0000);
    rdc(8'h15, 16'h0006);
    u_far.set_in(4, 1'b0);
    settle();
  endtask : t_restore
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    srst_i <= 1'b1;
    addr_i <= 8'h00;
    wdata_i <= 16'h0000;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    alm <= 6'h00;
    core <= 7'h00;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    done("reset");
    t_cmds();
    done("commands");
    t_prio();
    done("priority");
    t_levels();
    done("levels");
    t_alarm();
    done("alarms");
    t_ext();
    done("external");
    t_status();
    done("status");
    t_restore();
    done("restore");
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
